//--- core/ppm_pkg.sv
// Constants shared by the port pin mode controller.
// Assumes pins 0..7 are port 1 bits 0..7 and pins 8..15 port 3 bits 0..7.
package ppm_pkg;
	// Pin vector width.
	localparam int PIN_CNT = 16;
	// Register byte offsets.
	localparam logic [7:0] OFS_LATCH = 8'h00;
	localparam logic [7:0] OFS_MODE_LOW = 8'h04;
	localparam logic [7:0] OFS_MODE_HIGH = 8'h08;
	localparam logic [7:0] OFS_PIN_READ = 8'h0C;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	// Field positions.
	localparam int CTRL_PD_BIT = 0;
	localparam int STAT_FUSE_BIT = 0;
	localparam int STAT_AVAIL_LSB = 16;
	// Reset values; mode low set and high clear is input-only.
	localparam logic [15:0] LATCH_RST = 16'hFFFF;
	localparam logic [15:0] MODE_LOW_RST = 16'hFFFF;
	localparam logic [15:0] MODE_HIGH_RST = 16'h0000;
	// Pin groups.
	localparam logic [15:0] ANALOG_MASK = 16'h0003;
	localparam logic [15:0] WAKE_MASK = 16'h0C08;
	localparam logic [15:0] FULL_IO_MASK = 16'h0FFF;
	localparam logic [15:0] EXTCLK_PINS = 16'h0100;
	localparam logic [15:0] XTAL_PINS = 16'h0300;
	localparam logic [15:0] RSTPIN_PINS = 16'h0008;
	// Clock source strap codes.
	localparam logic [1:0] CLK_RC = 2'h0;
	localparam logic [1:0] CLK_EXT = 2'h1;
	localparam logic [1:0] CLK_XTAL = 2'h2;
	// Strong pull-up pulse length in clock cycles.
	localparam logic [1:0] STRONG_CYCLES = 2'h2;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Start-up sequencer states.
	typedef enum logic [1:0] {
		INIT_WAIT1,
		INIT_WAIT2,
		INIT_LOAD,
		INIT_RUN
	} ppm_init_e;
endpackage

//--- core/ppm_port_ctrl.sv
// Port pin mode controller: latch, per-pin mode bits and pad drive.
// Assumes an AXI4-Lite master on clk_sys and pads that resolve the
// drive, pull-up and Schmitt enables into real pin behaviour.
//
// Overview of operation
// - Two mode bits per pin pick mode.
// - Tristate fuse set: all usable pins input-only.
// - Fuse clear: quasi mode, analog pins input-only.
// - Power-down keeps only wake pin inputs enabled.
// - Quasi: very weak pull-up follows latch one.
// - Quasi: weak pull-up needs latch and pin high.
// - Quasi: latch rise gives two-cycle strong pull-up.
// - Quasi: latch zero drives pin low.
// - Input-only: all drivers and pulls off.
// - Clock and reset straps remove pins.
// - Open-drain: no pull-ups, pull-down on zero.
// - Push-pull: strong high on one, low on zero.
`timescale 1ns/1ps
`default_nettype none
module ppm_port_ctrl #(
	parameter int AW = 5
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output var logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output var logic s_axi_wready,
	output var logic [1:0] s_axi_bresp,
	output var logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output var logic s_axi_arready,
	output var logic [31:0] s_axi_rdata,
	output var logic [1:0] s_axi_rresp,
	output var logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tristateFuse,
	input wire logic [1:0] clkSrcSel,
	input wire logic extResetPinEn,
	input wire logic [15:0] padIn,
	output var logic [15:0] padOut,
	output var logic [15:0] padOe,
	output var logic [15:0] padVeryWeakPu,
	output var logic [15:0] padWeakPu,
	output var logic [15:0] padSchmittEn
);
	localparam int N = ppm_pkg::PIN_CNT;

	// True when the address selects the word at the given offset.
	function automatic logic regIs(input logic [AW-1:0] a,
		input logic [7:0] ofs);
		regIs = (a[AW-1:2] == ofs[AW-1:2]);
	endfunction

	// True when the address selects any mapped register.
	function automatic logic regHit(input logic [AW-1:0] a);
		regHit = regIs(a, ppm_pkg::OFS_LATCH) ||
			regIs(a, ppm_pkg::OFS_MODE_LOW) ||
			regIs(a, ppm_pkg::OFS_MODE_HIGH) ||
			regIs(a, ppm_pkg::OFS_PIN_READ) ||
			regIs(a, ppm_pkg::OFS_CTRL) ||
			regIs(a, ppm_pkg::OFS_STATUS);
	endfunction

	// Merges the two low byte lanes of a write into a 16-bit register.
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Usable pins left once clock and reset pins are taken.
	function automatic logic [15:0] availFrom(input logic [1:0] cs,
		input logic re);
		logic [15:0] m;
		m = ppm_pkg::FULL_IO_MASK;
		if (cs == ppm_pkg::CLK_EXT) begin
			m = m & ~ppm_pkg::EXTCLK_PINS;
		end else if (cs == ppm_pkg::CLK_XTAL) begin
			m = m & ~ppm_pkg::XTAL_PINS;
		end
		if (re) begin
			m = m & ~ppm_pkg::RSTPIN_PINS;
		end
		availFrom = m;
	endfunction

	logic rstMeta_reg, rstN_reg;
	logic [15:0] padMeta_reg, padSync_reg;
	logic [3:0] strapMeta_reg, strapSync_reg;
	ppm_pkg::ppm_init_e initState_reg;
	logic fuseCap_reg;
	logic [15:0] availMask_reg;
	logic [15:0] latch_reg, latchNext;
	logic [15:0] modeLow_reg, modeHigh_reg;
	logic powerDown_reg;
	logic [1:0] strongCnt_reg [N];
	logic [AW-1:0] awAddr_reg;
	logic awHeld_reg, wHeld_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic wrFire;
	logic [31:0] rdMux;
	logic [15:0] qbV, ppV, odV, inV, strongV;

	// Reset release through two flip-flops.
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_reg <= 1'b0;
			rstN_reg <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstN_reg <= rstMeta_reg;
		end
	end

	// Pin levels and straps cross in through two flip-flops.
	always_ff @(posedge clk_sys or negedge rstN_reg) begin
		if (!rstN_reg) begin
			padMeta_reg <= '0;
			padSync_reg <= '0;
			strapMeta_reg <= '0;
			strapSync_reg <= '0;
		end else begin
			padMeta_reg <= padIn;
			padSync_reg <= padMeta_reg;
			strapMeta_reg <= {tristateFuse, clkSrcSel, extResetPinEn};
			strapSync_reg <= strapMeta_reg;
		end
	end

	// Start-up sequencer waits for the straps, then captures them.
	always_ff @(posedge clk_sys or negedge rstN_reg) begin
		if (!rstN_reg) begin
			initState_reg <= ppm_pkg::INIT_WAIT1;
			fuseCap_reg <= 1'b0;
			availMask_reg <= '0;
		end else begin
			case (initState_reg)
				ppm_pkg::INIT_WAIT1: begin
					initState_reg <= ppm_pkg::INIT_WAIT2;
				end
				ppm_pkg::INIT_WAIT2: begin
					initState_reg <= ppm_pkg::INIT_LOAD;
				end
				ppm_pkg::INIT_LOAD: begin
					fuseCap_reg <= strapSync_reg[3];
					availMask_reg <= availFrom(strapSync_reg[2:1],
						strapSync_reg[0]);
					initState_reg <= ppm_pkg::INIT_RUN;
				end
				default: begin
					initState_reg <= ppm_pkg::INIT_RUN;
				end
			endcase
		end
	end

	// A write completes once both address and data are held.
	assign wrFire = awHeld_reg && wHeld_reg && !s_axi_bvalid;

	// Write address, data and response channels.
	always_ff @(posedge clk_sys or negedge rstN_reg) begin
		if (!rstN_reg) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ppm_pkg::RESP_OKAY;
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= '0;
			wData_reg <= '0;
			wStrb_reg <= '0;
		end else begin
			if (initState_reg == ppm_pkg::INIT_LOAD) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_reg <= s_axi_awaddr;
				awHeld_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
				wHeld_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wrFire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= regHit(awAddr_reg) ? ppm_pkg::RESP_OKAY :
					ppm_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Next port latch value after a software write.
	always_comb begin
		latchNext = latch_reg;
		if (wrFire && regIs(awAddr_reg, ppm_pkg::OFS_LATCH)) begin
			latchNext = merge16(latch_reg, wData_reg, wStrb_reg);
		end
	end

	// Latch, mode bits and power-down control.
	always_ff @(posedge clk_sys or negedge rstN_reg) begin
		if (!rstN_reg) begin
			latch_reg <= ppm_pkg::LATCH_RST;
			modeLow_reg <= ppm_pkg::MODE_LOW_RST;
			modeHigh_reg <= ppm_pkg::MODE_HIGH_RST;
			powerDown_reg <= 1'b0;
		end else begin
			latch_reg <= latchNext;
			if (initState_reg == ppm_pkg::INIT_LOAD && !strapSync_reg[3]) begin
				modeLow_reg <= ppm_pkg::ANALOG_MASK;
				modeHigh_reg <= ppm_pkg::MODE_HIGH_RST;
			end
			if (wrFire && regIs(awAddr_reg, ppm_pkg::OFS_MODE_LOW)) begin
				modeLow_reg <= merge16(modeLow_reg, wData_reg, wStrb_reg);
			end
			if (wrFire && regIs(awAddr_reg, ppm_pkg::OFS_MODE_HIGH)) begin
				modeHigh_reg <= merge16(modeHigh_reg, wData_reg, wStrb_reg);
			end
			if (wrFire && regIs(awAddr_reg, ppm_pkg::OFS_CTRL) &&
				wStrb_reg[0]) begin
				powerDown_reg <= wData_reg[ppm_pkg::CTRL_PD_BIT];
			end
		end
	end

	// Strong pull-up timer, loaded on each zero-to-one latch change.
	always_ff @(posedge clk_sys or negedge rstN_reg) begin
		if (!rstN_reg) begin
			for (int i = 0; i < N; i++) begin
				strongCnt_reg[i] <= '0;
			end
		end else begin
			for (int i = 0; i < N; i++) begin
				if (latchNext[i] && !latch_reg[i]) begin
					strongCnt_reg[i] <= ppm_pkg::STRONG_CYCLES;
				end else if (strongCnt_reg[i] != 2'h0) begin
					strongCnt_reg[i] <= strongCnt_reg[i] - 2'h1;
				end
			end
		end
	end

	// Mode decode per pin; unusable pins fall in no mode at all.
	always_comb begin
		qbV = ~modeLow_reg & ~modeHigh_reg & availMask_reg;
		ppV = ~modeLow_reg & modeHigh_reg & availMask_reg;
		inV = modeLow_reg & ~modeHigh_reg & availMask_reg;
		odV = modeLow_reg & modeHigh_reg & availMask_reg;
		for (int i = 0; i < N; i++) begin
			strongV[i] = (strongCnt_reg[i] != 2'h0);
		end
	end

	// Pad drive, pulls and Schmitt enables, all from flip-flops.
	always_ff @(posedge clk_sys or negedge rstN_reg) begin
		if (!rstN_reg) begin
			padOut <= '0;
			padOe <= '0;
			padVeryWeakPu <= '0;
			padWeakPu <= '0;
			padSchmittEn <= '0;
		end else begin
			padOe <= (qbV & (~latch_reg | strongV)) | ppV |
				(odV & ~latch_reg);
			padOut <= (qbV & latch_reg & strongV) |
				(ppV & latch_reg);
			padVeryWeakPu <= qbV & latch_reg;
			padWeakPu <= qbV & latch_reg & padSync_reg;
			padSchmittEn <= availMask_reg &
				(~{N{powerDown_reg}} | ppm_pkg::WAKE_MASK);
		end
	end

	// Read data; gated inputs read as zero.
	always_comb begin
		rdMux = '0;
		if (regIs(s_axi_araddr, ppm_pkg::OFS_LATCH)) begin
			rdMux[15:0] = latch_reg;
		end else if (regIs(s_axi_araddr, ppm_pkg::OFS_MODE_LOW)) begin
			rdMux[15:0] = modeLow_reg;
		end else if (regIs(s_axi_araddr, ppm_pkg::OFS_MODE_HIGH)) begin
			rdMux[15:0] = modeHigh_reg;
		end else if (regIs(s_axi_araddr, ppm_pkg::OFS_PIN_READ)) begin
			rdMux[15:0] = padSync_reg & padSchmittEn;
		end else if (regIs(s_axi_araddr, ppm_pkg::OFS_CTRL)) begin
			rdMux[ppm_pkg::CTRL_PD_BIT] = powerDown_reg;
		end else if (regIs(s_axi_araddr, ppm_pkg::OFS_STATUS)) begin
			rdMux[ppm_pkg::STAT_FUSE_BIT] = fuseCap_reg;
			rdMux[ppm_pkg::STAT_AVAIL_LSB +: 16] = availMask_reg;
		end
	end

	// Read address and data channels.
	always_ff @(posedge clk_sys or negedge rstN_reg) begin
		if (!rstN_reg) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= ppm_pkg::RESP_OKAY;
		end else begin
			if (initState_reg == ppm_pkg::INIT_LOAD) begin
				s_axi_arready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdMux;
				s_axi_rresp <= regHit(s_axi_araddr) ? ppm_pkg::RESP_OKAY :
					ppm_pkg::RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Checks on pad behaviour against mode, latch and straps.
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstN_reg);

	property p_push_pull;
		ppV != '0 |=> ((padOe & $past(ppV)) == $past(ppV)) &&
			((padOut & $past(ppV)) == $past(latch_reg & ppV));
	endproperty
	a_push_pull: assert property (p_push_pull)
		else $error("Push-pull pin not driven from its latch.");

	property p_fuse_input;
		(initState_reg == ppm_pkg::INIT_LOAD && strapSync_reg[3]) |=>
			modeLow_reg == ppm_pkg::MODE_LOW_RST &&
			modeHigh_reg == ppm_pkg::MODE_HIGH_RST;
	endproperty
	a_fuse_input: assert property (p_fuse_input)
		else $error("Fuse set but pins not input-only.");

	property p_fuse_quasi;
		(initState_reg == ppm_pkg::INIT_LOAD && !strapSync_reg[3]) |=>
			modeLow_reg == ppm_pkg::ANALOG_MASK &&
			modeHigh_reg == ppm_pkg::MODE_HIGH_RST;
	endproperty
	a_fuse_quasi: assert property (p_fuse_quasi)
		else $error("Fuse clear but reset modes wrong.");

	property p_power_down;
		powerDown_reg |=>
			padSchmittEn == $past(availMask_reg & ppm_pkg::WAKE_MASK);
	endproperty
	a_power_down: assert property (p_power_down)
		else $error("Schmitt enables wrong in power-down.");

	property p_very_weak;
		##1 padVeryWeakPu == $past(qbV & latch_reg);
	endproperty
	a_very_weak: assert property (p_very_weak)
		else $error("Very weak pull-up does not follow latch.");

	property p_weak;
		##1 padWeakPu == $past(qbV & latch_reg & padSync_reg);
	endproperty
	a_weak: assert property (p_weak)
		else $error("Weak pull-up on while pin or latch low.");

	property p_strong;
		($rose(latch_reg[2]) && qbV[2]) ##1
			(qbV[2] && latch_reg[2]) [*2] |->
			$past(padOe[2]) && padOe[2] && padOut[2] ##1 !padOe[2];
	endproperty
	a_strong: assert property (p_strong)
		else $error("Strong pull-up not exactly two cycles.");

	property p_quasi_low;
		##1 (padOe & ~padOut & $past(qbV & ~latch_reg)) ==
			$past(qbV & ~latch_reg);
	endproperty
	a_quasi_low: assert property (p_quasi_low)
		else $error("Quasi pin with latch zero not driven low.");

	property p_input_off;
		inV != '0 |=> ((padOe | padVeryWeakPu | padWeakPu) &
			$past(inV)) == '0;
	endproperty
	a_input_off: assert property (p_input_off)
		else $error("Input-only pin has a driver on.");

	property p_unavail;
		##1 ((padOe | padVeryWeakPu | padWeakPu | padSchmittEn) &
			~$past(availMask_reg)) == '0;
	endproperty
	a_unavail: assert property (p_unavail)
		else $error("Unusable pin is driven or sensed.");

	property p_open_drain;
		odV != '0 |=> ((padVeryWeakPu | padWeakPu | padOut) &
			$past(odV)) == '0 &&
			(padOe & $past(odV)) == $past(odV & ~latch_reg);
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("Open-drain pin drive wrong.");

	// Only edges taken out of reset are checked; the flops load zero before.
	property p_sync;
		rstN_reg |-> ##2 padSync_reg == $past(padIn, 2);
	endproperty
	a_sync: assert property (p_sync)
		else $error("Pin level not delayed by two flip-flops.");

	c_strong: cover property (qbV[2] && padOe[2] && padOut[2]);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_pd: cover property (powerDown_reg && padSchmittEn != '0);
endmodule
`default_nettype wire

//--- tb/ppm_pin_model.sv
// Outside circuitry of the port: turns pad drive into sensed levels.
// Assumes the controller's pad outputs and an outside drive from the bench.
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_model (
	input wire logic clk_sys,
	input wire logic [15:0] padOut,
	input wire logic [15:0] padOe,
	input wire logic [15:0] padVeryWeakPu,
	input wire logic [15:0] padWeakPu,
	input wire logic [15:0] extEn,
	input wire logic [15:0] extVal,
	output logic [15:0] padIn
);
	logic flt = 1'h0;
	// A pin that nobody drives shows a level that flips every cycle; an undriven wake pin reads low.
	always @(posedge clk_sys) flt <= ~flt;
	// Strong drive wins, then the outside driver, then the pull-ups.
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			if (padOe[i])
				padIn[i] = padOut[i];
			else if (extEn[i])
				padIn[i] = extVal[i];
			else if (padVeryWeakPu[i] || padWeakPu[i])
				padIn[i] = 1'h1;
			else if (ppm_pkg::WAKE_MASK[i])
				padIn[i] = 1'h0;
			else
				padIn[i] = flt;
		end
	end
endmodule
`default_nettype wire

//--- tb/port_pin_mode_control_tb_top.sv
// Self-checking bench of the port pin mode controller.
// Assumes the pin model on the pads and an AXI4-Lite master made here.
`timescale 1ns/1ps
`default_nettype none
module port_pin_mode_control_tb_top;
	logic clk_sys = 1'h0;
	logic arst_n = 1'h0;
	logic [4:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = '0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic tristateFuse = 1'h0, extResetPinEn = 1'h0;
	logic [1:0] clkSrcSel = '0;
	logic [15:0] padIn, padOut, padOe, padVeryWeakPu, padWeakPu;
	logic [15:0] padSchmittEn;
	logic [15:0] extEn = '0, extVal = '0, r, av;
	logic f;
	logic [33:0] expQ[$];
	int selQ[$];
	int failures = 0, compares = 0, seed = 58, padPin = 0;
	logic padReq = 1'h0;
	logic [4:0] tab[8] = '{5'h11, 5'h07, 5'h11, 5'h19,
		5'h01, 5'h01, 5'h11, 5'h01};

	ppm_port_ctrl #(.AW(5)) i_ppm_port_ctrl (.clk_sys, .arst_n,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .tristateFuse, .clkSrcSel, .extResetPinEn, .padIn,
		.padOut, .padOe, .padVeryWeakPu, .padWeakPu, .padSchmittEn);
	ppm_pin_model i_ppm_pin_model (.clk_sys, .padOut, .padOe,
		.padVeryWeakPu, .padWeakPu, .extEn, .extVal, .padIn);

	// The system clock, 10 ns period.
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	// Notes an expected result for the watching process.
	task automatic note(input int s, input logic [33:0] e);
		selQ.push_back(s);
		expQ.push_back(e);
	endtask

	// Compares a seen result with the oldest note.
	task automatic cmp(input int s, input logic [33:0] v);
		logic [33:0] e;
		int k;
		compares++;
		k = -1;
		e = '0;
		if (selQ.size() > 0) begin
			k = selQ.pop_front();
			e = expQ.pop_front();
		end
		if (k >= 32) begin
			v &= 34'(k[4:0]);
			e &= 34'(k[4:0]);
			k = 32;
		end
		if (k != s || v !== e) begin
			$display("BAD %0t kind %0d got %h want %h", $time, s, v, e);
			failures++;
		end
	endtask

	// Bus answers are compared at the handshake edge.
	always @(posedge clk_sys) begin
		if (s_axi_rvalid === 1'h1 && s_axi_rready)
			cmp(0, {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid === 1'h1 && s_axi_bready)
			cmp(1, {32'h0, s_axi_bresp});
	end

	// Pad state of one pin is compared mid-cycle when asked.
	always @(negedge clk_sys) begin
		if (padReq) begin
			padReq = 1'h0;
			cmp(32, {29'h0, padOe[padPin], padOe[padPin] & padOut[padPin],
				padVeryWeakPu[padPin], padWeakPu[padPin],
				padSchmittEn[padPin]});
		end
	end

	// Asks for one pad check; bits are oe, driven high, pull-ups, input.
	task automatic pchk(input int p, input logic [4:0] e, input logic [4:0] m);
		note(32 + m, {29'h0, e});
		padPin = p;
		padReq = 1'h1;
		@(posedge clk_sys);
	endtask

	// One AXI4-Lite write; address and data are released as each is taken.
	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		input logic [1:0] rs = ppm_pkg::RESP_OKAY);
		bit aw, w;
		note(1, {32'h0, rs});
		@(posedge clk_sys);
		s_axi_awaddr <= a[4:0];
		s_axi_wdata <= {16'h0, d};
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		aw = 0;
		w = 0;
		while (!(aw && w)) begin
			@(posedge clk_sys);
			if (!aw && s_axi_awready) begin
				aw = 1;
				s_axi_awvalid <= 1'h0;
			end
			if (!w && s_axi_wready) begin
				w = 1;
				s_axi_wvalid <= 1'h0;
			end
		end
		do @(posedge clk_sys); while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
	endtask

	// One AXI4-Lite read.
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] rs = ppm_pkg::RESP_OKAY);
		note(0, {rs, d});
		@(posedge clk_sys);
		s_axi_araddr <= a[4:0];
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk_sys); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk_sys); while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
	endtask

	// Resets for 8 cycles with the given straps, then lets start-up end.
	task automatic rst(input logic tf, input logic [1:0] c, input logic e);
		@(posedge clk_sys);
		arst_n <= 1'h0;
		tristateFuse <= tf;
		clkSrcSel <= c;
		extResetPinEn <= e;
		repeat (8) @(posedge clk_sys);
		arst_n <= 1'h1;
		repeat (8) @(posedge clk_sys);
	endtask

	// Prints the verdict and ends the run.
	task automatic end_of_test();
		if (failures == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence: defaults, pin reads, power-down, pulse, modes, straps.
	initial begin
		rst(1'h0, 2'h0, 1'h0);
		rd(ppm_pkg::OFS_LATCH, 32'h0000FFFF);
		rd(ppm_pkg::OFS_MODE_LOW, 32'h00000003);
		rd(ppm_pkg::OFS_MODE_HIGH, 32'h00000000);
		pchk(0, 5'h01, 5'h1F);
		pchk(5, 5'h07, 5'h1F);
		pchk(13, 5'h00, 5'h1F);
		r = 16'($random(seed));
		extEn <= 16'hFFFF;
		extVal <= r;
		repeat (4) @(posedge clk_sys);
		rd(ppm_pkg::OFS_PIN_READ, {16'h0, r & ppm_pkg::FULL_IO_MASK});
		pchk(5, {3'h1, r[5], 1'h1}, 5'h1F);
		wr(ppm_pkg::OFS_CTRL, 16'h0001);
		rd(ppm_pkg::OFS_PIN_READ, {16'h0, r & ppm_pkg::WAKE_MASK});
		for (int p = 0; p < 16; p++) begin
			pchk(p, {4'h0, ppm_pkg::WAKE_MASK[p]}, 5'h01);
		end
		wr(ppm_pkg::OFS_CTRL, 16'h0000);
		extEn <= 16'h0000;
		wr(ppm_pkg::OFS_LATCH, 16'hFFDB);
		pchk(5, 5'h10, 5'h1C);
		repeat (4) @(posedge clk_sys);
		wr(ppm_pkg::OFS_LATCH, 16'hFFFF);
		pchk(5, 5'h18, 5'h18);
		pchk(5, 5'h18, 5'h18);
		pchk(5, 5'h00, 5'h18);
		for (int m = 0; m < 4; m++) begin
			wr(ppm_pkg::OFS_MODE_LOW, 16'h0003 | 16'(m[1]) << 6);
			wr(ppm_pkg::OFS_MODE_HIGH, 16'(m[0]) << 6);
			for (int l = 1; l >= 0; l--) begin
				wr(ppm_pkg::OFS_LATCH, 16'hFFBF | 16'(l) << 6);
				repeat (6) @(posedge clk_sys);
				pchk(6, tab[m * 2 + l], 5'h1F);
			end
		end
		wr(8'h18, 16'h1234, ppm_pkg::RESP_SLVERR);
		rd(8'h18, 32'h0, ppm_pkg::RESP_SLVERR);
		for (int k = 0; k < 8; k++) begin
			f = 1'($random(seed));
			rst(f, 2'(k % 4), 1'(k / 4));
			av = ppm_pkg::FULL_IO_MASK;
			if (k % 4 == 1)
				av &= ~ppm_pkg::EXTCLK_PINS;
			if (k % 4 == 2)
				av &= ~ppm_pkg::XTAL_PINS;
			if (k >= 4)
				av &= ~ppm_pkg::RSTPIN_PINS;
			wr(ppm_pkg::OFS_STATUS, 16'h0000);
			rd(ppm_pkg::OFS_STATUS, {av, 15'h0, f});
			rd(ppm_pkg::OFS_MODE_LOW, f ? 32'hFFFF : 32'h0003);
		end
		end_of_test();
	end

	// Cuts a hung run short.
	initial begin
		#200000;
		failures++;
		end_of_test();
	end
endmodule
`default_nettype wire
